//--- design/pced_pkg.sv
package pced_pkg;
  localparam int          NUM_PINS      = 6;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 4;
  // register byte offsets
  localparam logic [3:0]  OFF_RISE_EN   = 4'h0;
  localparam logic [3:0]  OFF_FALL_EN   = 4'h4;
  localparam logic [3:0]  OFF_FLAGS     = 4'h8;
  localparam logic [3:0]  OFF_CTRL      = 4'hC;
  // control register layout
  localparam int          CTRL_MEN_BIT  = 0;
  localparam int          CTRL_SUM_BIT  = 1;
  localparam int          CTRL_MASK_BIT = 2;
  localparam logic [5:0]  PIN_RESET     = 6'h00;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [1:0]  UNIMPL_BITS   = 2'h0;
endpackage

//--- design/pced_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser plus history stage for edge detection
module pced_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] pin_i,
  output logic      [5:0] rise_o,
  output logic      [5:0] fall_o
);
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [5:0] prev_reg;

  // the meta stage feeds only sync_reg
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= pced_pkg::PIN_RESET;
      sync_reg <= pced_pkg::PIN_RESET;
      prev_reg <= pced_pkg::PIN_RESET;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;
endmodule // pced_sync

//--- design/pced_top.sv
// Operation
// - each pin has a rising-edge enable; enabled low-to-high transition is an event
// - each pin has a falling-edge enable; enabled high-to-low transition is an event
// - with both enables clear a pin never produces an event
// - an enabled edge sets that pin's change flag
// - an enabled edge sets the pin flag and the summary request together
// - change flags are hardware set and software readable and writable
// - flag reads zero until a change; writing zero clears it
// - bits 7 and 6 of the three registers ignore writes, read zero
// - all enable and flag bits reset to zero on every reset
// - detection and flag setting continue with master enable off
// - summary bit is the OR of all six change flags
// - an edge during a clearing write leaves the flag set
// - edges in sleep set flags; wake request only with master enable
`timescale 1ns/1ps
module pced_top (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] port_pin_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             irq_o,
  output logic             wake_o
);
  //////////////////////////////////////////////////////////////////////////////
  logic [5:0] rise_pulse;
  logic [5:0] fall_pulse;
  logic [5:0] rise_edge_enable_reg;
  logic [5:0] fall_edge_enable_reg;
  logic [5:0] change_flags_reg;
  logic [5:0] change_flags_next;
  logic       change_irq_master_enable_reg;
  logic       irq_mask_reg;
  logic       ack_reg;
  logic       err_reg;
  logic [31:0] rdata_reg;
  logic [5:0] event_hit;
  logic       change_irq_summary;
  logic       req;
  logic       wr_en;

  pced_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (port_pin_i),
    .rise_o (rise_pulse),
    .fall_o (fall_pulse)
  );

  // detection ignores the master enable on purpose
  assign event_hit = (rise_pulse & rise_edge_enable_reg) | (fall_pulse & fall_edge_enable_reg);

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
    addr_hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // wishbone classic slave: ack one cycle after the strobe, dropped next cycle
  assign req   = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  assign wr_en = req & wb_we_i & wb_sel_i[0];
  logic mapped;
  assign mapped = addr_hit(wb_adr_i, pced_pkg::OFF_RISE_EN) | addr_hit(wb_adr_i, pced_pkg::OFF_FALL_EN) |
                  addr_hit(wb_adr_i, pced_pkg::OFF_FLAGS) | addr_hit(wb_adr_i, pced_pkg::OFF_CTRL);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= req & mapped;
      err_reg <= req & ~mapped;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (req)
    begin
      rdata_reg <= 32'h0000_0000;
      unique case (wb_adr_i)
        pced_pkg::OFF_RISE_EN: rdata_reg[7:0] <= {pced_pkg::UNIMPL_BITS, rise_edge_enable_reg};
        pced_pkg::OFF_FALL_EN: rdata_reg[7:0] <= {pced_pkg::UNIMPL_BITS, fall_edge_enable_reg};
        pced_pkg::OFF_FLAGS:   rdata_reg[7:0] <= {pced_pkg::UNIMPL_BITS, change_flags_reg};
        pced_pkg::OFF_CTRL:    rdata_reg[7:0] <= {5'h00, irq_mask_reg, change_irq_summary,
                                                  change_irq_master_enable_reg};
        default:               rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // enable registers; bits 7:6 are never stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rise_edge_enable_reg <= pced_pkg::PIN_RESET;
      fall_edge_enable_reg <= pced_pkg::PIN_RESET;
    end
    else if (wr_en)
    begin
      if (addr_hit(wb_adr_i, pced_pkg::OFF_RISE_EN))
        rise_edge_enable_reg <= wb_dat_i[5:0];
      if (addr_hit(wb_adr_i, pced_pkg::OFF_FALL_EN))
        fall_edge_enable_reg <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      change_irq_master_enable_reg <= 1'b0;
      irq_mask_reg                 <= 1'b0;
    end
    else if (wr_en && addr_hit(wb_adr_i, pced_pkg::OFF_CTRL))
    begin
      change_irq_master_enable_reg <= wb_dat_i[pced_pkg::CTRL_MEN_BIT];
      irq_mask_reg                 <= wb_dat_i[pced_pkg::CTRL_MASK_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags: software writes the stored value, a simultaneous edge wins
  always_comb
  begin
    change_flags_next = change_flags_reg;
    if (wr_en && addr_hit(wb_adr_i, pced_pkg::OFF_FLAGS))
      change_flags_next = wb_dat_i[5:0];
    change_flags_next = change_flags_next | event_hit;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      change_flags_reg <= pced_pkg::PIN_RESET;
    else
      change_flags_reg <= change_flags_next;
  end

  assign change_irq_summary = |change_flags_reg;
  // the summary bit acts as the sticky status; clearing is done through the flags
  assign irq_o  = change_irq_summary & change_irq_master_enable_reg & irq_mask_reg;
  assign wake_o = change_irq_summary & change_irq_master_enable_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic past_valid_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      past_valid_reg <= 1'b0;
    else
      past_valid_reg <= 1'b1;
  end

  property p_rise_sets;
    @(posedge clk_i) disable iff (rst_i) (rise_pulse & rise_edge_enable_reg) != 6'h00 |=>
      ((change_flags_reg & $past(rise_pulse & rise_edge_enable_reg)) == $past(rise_pulse & rise_edge_enable_reg));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge did not set flag");

  property p_fall_sets;
    @(posedge clk_i) disable iff (rst_i) (fall_pulse & fall_edge_enable_reg) != 6'h00 |=>
      ((change_flags_reg & $past(fall_pulse & fall_edge_enable_reg)) == $past(fall_pulse & fall_edge_enable_reg));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge did not set flag");

  property p_no_enable_no_set;
    @(posedge clk_i) disable iff (rst_i)
      (rise_edge_enable_reg == 6'h00 && fall_edge_enable_reg == 6'h00 && !wr_en) |=> change_flags_reg == $past(change_flags_reg);
  endproperty
  a_no_enable_no_set: assert property (p_no_enable_no_set) else $error("flag changed without enable");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (rst_i) !wr_en |=> (change_flags_reg & $past(change_flags_reg)) == $past(change_flags_reg);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without write");

  property p_clear_write;
    @(posedge clk_i) disable iff (rst_i) (wr_en && wb_adr_i == pced_pkg::OFF_FLAGS && event_hit == 6'h00) |=>
      change_flags_reg == $past(wb_dat_i[5:0]);
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("flag write not applied");

  property p_set_beats_clear;
    @(posedge clk_i) disable iff (rst_i) (wr_en && wb_adr_i == pced_pkg::OFF_FLAGS && event_hit != 6'h00) |=>
      (change_flags_reg & $past(event_hit)) == $past(event_hit);
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("edge lost during clear");

  property p_summary;
    @(posedge clk_i) disable iff (rst_i) (rdata_reg[pced_pkg::CTRL_SUM_BIT] != $past(|change_flags_reg)) |->
      !($past(ack_reg) == 1'b0 && ack_reg && $past(wb_adr_i) == pced_pkg::OFF_CTRL && past_valid_reg);
  endproperty
  a_summary: assert property (p_summary) else $error("summary read mismatch");

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i) irq_o |-> (change_flags_reg != 6'h00 && change_irq_master_enable_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without cause");

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (rst_i) ack_reg |-> rdata_reg[31:8] == 24'h000000 &&
      ($past(wb_adr_i) == pced_pkg::OFF_CTRL || rdata_reg[7:6] == 2'h0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i) ack_reg |=> !ack_reg;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");

  property p_err_unmapped;
    @(posedge clk_i) disable iff (rst_i) (req && !mapped) |=> (err_reg && !ack_reg);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  // software owns the enables; no other path may move them
  property p_rise_en_hold;
    @(posedge clk_i) disable iff (rst_i) !(wr_en && addr_hit(wb_adr_i, pced_pkg::OFF_RISE_EN)) |=>
      rise_edge_enable_reg == $past(rise_edge_enable_reg);
  endproperty
  a_rise_en_hold: assert property (p_rise_en_hold) else $error("rising enable changed without write");

  property p_fall_en_hold;
    @(posedge clk_i) disable iff (rst_i) !(wr_en && addr_hit(wb_adr_i, pced_pkg::OFF_FALL_EN)) |=>
      fall_edge_enable_reg == $past(fall_edge_enable_reg);
  endproperty
  a_fall_en_hold: assert property (p_fall_en_hold) else $error("falling enable changed without write");

  property p_ctrl_hold;
    @(posedge clk_i) disable iff (rst_i) !(wr_en && addr_hit(wb_adr_i, pced_pkg::OFF_CTRL)) |=>
      (change_irq_master_enable_reg == $past(change_irq_master_enable_reg) && irq_mask_reg == $past(irq_mask_reg));
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control bits changed without write");

  property p_reset_clear;
    @(posedge clk_i) rst_i |=> (rise_edge_enable_reg == pced_pkg::PIN_RESET && fall_edge_enable_reg == pced_pkg::PIN_RESET &&
      change_flags_reg == pced_pkg::PIN_RESET && !change_irq_master_enable_reg && !irq_mask_reg);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

  property p_reset_outputs;
    @(posedge clk_i) rst_i |=> (!wb_ack_o && !wb_err_o && !irq_o && !wake_o);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("output active after reset");

  property p_no_event_hold;
    @(posedge clk_i) disable iff (rst_i) (!wr_en && event_hit == pced_pkg::PIN_RESET) |=>
      change_flags_reg == $past(change_flags_reg);
  endproperty
  a_no_event_hold: assert property (p_no_event_hold) else $error("flag moved with no edge and no write");

  property p_event_summary;
    @(posedge clk_i) disable iff (rst_i) (event_hit != pced_pkg::PIN_RESET) |=> change_irq_summary;
  endproperty
  a_event_summary: assert property (p_event_summary) else $error("edge did not raise summary");

  // a disabled master enable must not starve the flags
  property p_detect_master_off;
    @(posedge clk_i) disable iff (rst_i) (!change_irq_master_enable_reg && event_hit != pced_pkg::PIN_RESET) |=>
      (change_flags_reg & $past(event_hit)) == $past(event_hit);
  endproperty
  a_detect_master_off: assert property (p_detect_master_off) else $error("edge lost with master off");

  property p_quiet_flags;
    @(posedge clk_i) disable iff (rst_i) (change_flags_reg == pced_pkg::PIN_RESET) |-> (!irq_o && !wake_o);
  endproperty
  a_quiet_flags: assert property (p_quiet_flags) else $error("request with no flag set");

  property p_single_rise;
    @(posedge clk_i) disable iff (rst_i) (rise_pulse != pced_pkg::PIN_RESET) |=> (rise_pulse & $past(rise_pulse)) == 6'h00;
  endproperty
  a_single_rise: assert property (p_single_rise) else $error("rising pulse longer than one cycle");

  property p_single_fall;
    @(posedge clk_i) disable iff (rst_i) (fall_pulse != pced_pkg::PIN_RESET) |=> (fall_pulse & $past(fall_pulse)) == 6'h00;
  endproperty
  a_single_fall: assert property (p_single_fall) else $error("falling pulse longer than one cycle");

  property p_pulse_exclusive;
    @(posedge clk_i) disable iff (rst_i) (rise_pulse & fall_pulse) == pced_pkg::PIN_RESET;
  endproperty
  a_pulse_exclusive: assert property (p_pulse_exclusive) else $error("rise and fall pulse on one pin");

  property p_read_flags;
    @(posedge clk_i) disable iff (rst_i) (ack_reg && past_valid_reg && $past(wb_adr_i) == pced_pkg::OFF_FLAGS) |->
      rdata_reg[5:0] == $past(change_flags_reg);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag read mismatch");

  property p_read_rise;
    @(posedge clk_i) disable iff (rst_i) (ack_reg && past_valid_reg && $past(wb_adr_i) == pced_pkg::OFF_RISE_EN) |->
      rdata_reg[5:0] == $past(rise_edge_enable_reg);
  endproperty
  a_read_rise: assert property (p_read_rise) else $error("rising enable read mismatch");

  // plain clearing write with no competing edge
  c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
                           wr_en && wb_adr_i == pced_pkg::OFF_FLAGS && event_hit == 6'h00);
  c_rise:  cover property (@(posedge clk_i) disable iff (rst_i) (rise_pulse & rise_edge_enable_reg) != 6'h00);
  c_fall:  cover property (@(posedge clk_i) disable iff (rst_i) (fall_pulse & fall_edge_enable_reg) != 6'h00);
  c_race:  cover property (@(posedge clk_i) disable iff (rst_i)
                           wr_en && wb_adr_i == pced_pkg::OFF_FLAGS && event_hit != 6'h00);
  c_irq:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule // pced_top

//--- tb/pced_pins.sv
`timescale 1ns/1ps
// far-side model: pins follow the requested level after a settable lag
module pced_pins (
  input  wire logic       clk_i,
  input  wire logic [5:0] lvl_i,
  input  wire logic [3:0] dly_i,
  output logic      [5:0] pin_o
);
  logic [3:0] wait_reg;
  initial pin_o = 6'h00;
  initial wait_reg = 4'h0;
  // a lag of zero answers at once, larger lags model a slow driver
  always @(posedge clk_i)
  begin
    if (lvl_i === pin_o)
      wait_reg <= 4'h0;
    else if (wait_reg >= dly_i)
      pin_o <= lvl_i;
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule // pced_pins

//--- tb/pin_change_edge_detector_tb.sv
`timescale 1ns/1ps
module pin_change_edge_detector_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [5:0]  port_pin, lvl = 6'h00;
  logic [3:0]  dly = 4'h0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0]  wb_adr = 4'h0, wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0, wb_dat_o;
  logic        wb_ack_o, wb_err_o, irq_o, wake_o;
  logic        exp_irq = 1'b0, exp_wake = 1'b0;
  logic [34:0] exp_q[$];
  logic [34:0] exp_v;
  logic [5:0]  r, f;
  int          bad_count = 0, num_checks = 0, cyc_cnt = 0;

  always #50 clk_i = ~clk_i;

  pced_pins u_pins (.clk_i(clk_i), .lvl_i(lvl), .dly_i(dly), .pin_o(port_pin));
  pced_top dut (.clk_i(clk_i), .rst_i(rst_i), .port_pin_i(port_pin), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o), .wake_o(wake_o));

  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // classic cycle: hold everything until ack or err is sampled high
  task xfer(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= s;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [5:0] d);
    xfer(1'b1, a, {26'h0, d});
  endtask

  task rd(input logic [3:0] a, input logic [5:0] d, input logic err = 1'b0);
    exp_q.push_back({err, exp_irq, exp_wake, 26'h0, d});
    xfer(1'b0, a, 32'h0);
  endtask

  // slack covers the slowest pin lag plus synchroniser depth
  task pins(input logic [5:0] v);
    @(posedge clk_i);
    lvl <= v;
    dly <= 4'($urandom % 8);
    repeat (20) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if ((wb_ack_o === 1'b1 || wb_err_o === 1'b1) && wb_we === 1'b0)
    begin
      exp_v = exp_q.pop_front();
      num_checks++;
      if ({wb_err_o, irq_o, wake_o, wb_dat_o} !== exp_v)
      begin
        bad_count++;
        $display("[FAIL] read adr %h expected %h seen %h", wb_adr, exp_v, {wb_err_o, irq_o, wake_o, wb_dat_o});
      end
    end
  end

  // ceiling is several times the length of the sequence below
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt > 4000)
    begin
      bad_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h43B3));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 6'h00); rd(4'h4, 6'h00); rd(4'h8, 6'h00); rd(4'hC, 6'h00);
    xfer(1'b1, 4'h0, 32'h3F, 4'hE); rd(4'h0, 6'h00);
    wr(4'h0, 6'h3F); rd(4'h0, 6'h3F);
    xfer(1'b1, 4'h4, 32'hFF); rd(4'h4, 6'h3F);
    xfer(1'b1, 4'h8, 32'hFF); rd(4'h8, 6'h3F);
    rd(4'hC, 6'h02);
    wr(4'h8, 6'h00); rd(4'h8, 6'h00);
    r = 6'($urandom) | 6'h01;
    f = 6'($urandom) | 6'h20;
    wr(4'h0, r); wr(4'h4, 6'h00);
    pins(6'h3F); rd(4'h8, r);
    pins(6'h00); rd(4'h8, r);
    wr(4'h8, 6'h00); wr(4'h0, 6'h00); wr(4'h4, f);
    pins(6'h3F); rd(4'h8, 6'h00);
    pins(6'h00); rd(4'h8, f);
    wr(4'h8, 6'h00); wr(4'h4, 6'h00);
    pins(6'h3F); pins(6'h00); rd(4'h8, 6'h00);
    wr(4'hC, 6'h04); wr(4'h4, 6'h3F);
    pins(6'h3F); pins(6'h00); rd(4'h8, 6'h3F);
    exp_irq = 1'b1; exp_wake = 1'b1;
    wr(4'hC, 6'h05); rd(4'hC, 6'h07);
    exp_irq = 1'b0;
    wr(4'hC, 6'h01); rd(4'hC, 6'h03);
    exp_wake = 1'b0;
    wr(4'h8, 6'h00); rd(4'hC, 6'h01);
    // pin edge reaches the flag exactly at the edge that takes the clearing write
    wr(4'h4, 6'h00); wr(4'h0, r);
    @(posedge clk_i);
    lvl <= 6'h3F;
    dly <= 4'h0;
    repeat (2) @(posedge clk_i);
    wr(4'h8, 6'h00);
    exp_wake = 1'b1;
    rd(4'h8, r);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    exp_wake = 1'b0;
    rd(4'h8, 6'h00); rd(4'h0, 6'h00); rd(4'hC, 6'h00);
    rd(4'h2, 6'h00, 1'b1);
    repeat (3) @(posedge clk_i);
    end_sim();
  end
endmodule // pin_change_edge_detector_tb
